/* shared/hstc_params.svh */
`ifndef HSTC_PARAMS_SVH
`define HSTC_PARAMS_SVH

// ==============================================================
// Register offsets on the 6-bit I/O space
`define HSTC_OFS_PLL_CTRL   6'h29
`define HSTC_OFS_IRQ_MASK   6'h39
`define HSTC_OFS_IRQ_FLAGS  6'h38
`define HSTC_OFS_CNT_LOW    6'h2e
`define HSTC_OFS_HIGH_TEMP  6'h25
`define HSTC_OFS_CMP_A      6'h2d
`define HSTC_OFS_CMP_B      6'h2c
`define HSTC_OFS_CMP_C      6'h2b
`define HSTC_OFS_CMP_D      6'h2a

// ==============================================================
// Field positions
`define HSTC_BIT_LOW_SPEED  7
`define HSTC_BIT_FAST_SEL   2
`define HSTC_BIT_PLL_START  1
`define HSTC_BIT_PLL_LOCK   0
`define HSTC_BIT_MATCH_D    7
`define HSTC_BIT_MATCH_A    6
`define HSTC_BIT_MATCH_B    5
`define HSTC_BIT_OVERFLOW   2

// ==============================================================
// Reset values and limits
`define HSTC_RST_BYTE       8'h00
`define HSTC_RST_CNT        10'h000
`define HSTC_RST_CMP        10'h000
`define HSTC_RST_CMP_C      10'h3ff
`define HSTC_CMP_C_MIN      10'h003
`define HSTC_FUSE_PLL       4'h1

// ==============================================================
// Interrupt vectors
`define HSTC_VEC_MATCH_D    5'h10
`define HSTC_VEC_MATCH_A    5'h03
`define HSTC_VEC_MATCH_B    5'h09
`define HSTC_VEC_OVERFLOW   5'h04
`define HSTC_VEC_NONE       5'h00

// ==============================================================
// Timing
`define HSTC_CORE_PERIOD_NS 10
`define HSTC_PLL_LOCK_US    100
`define HSTC_PLL_LOCK_CYC   ((`HSTC_PLL_LOCK_US * 1000) / `HSTC_CORE_PERIOD_NS)
`define HSTC_WR_SYNC_PS     15000
`define HSTC_WR_SYNC_CYC    ((`HSTC_WR_SYNC_PS + `HSTC_CORE_PERIOD_NS * 1000 - 1) / \
                             (`HSTC_CORE_PERIOD_NS * 1000))
`define HSTC_FAST_DIV       1
`define HSTC_LOW_SPEED_MUL  2

`endif

/* shared/hstc_pkg.sv */
package hstc_pkg;

  // ==============================================================
  // CPU I/O access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } hstc_io_req_t;

  // Event order used for flags, masks and requests: D, A, B, overflow
  typedef struct packed {
    logic match_d;
    logic match_a;
    logic match_b;
    logic overflow;
  } hstc_evt_t;

  typedef logic [9:0] hstc_cnt_t;

  typedef enum logic [1:0] {
    PLL_OFF,
    PLL_LOCKING,
    PLL_LOCKED
  } hstc_pll_state_t;

endpackage

/* logic/hstc_tick_gen.sv */
`timescale 1ns/1ps
`include "hstc_params.svh"

module hstc_tick_gen import hstc_pkg::*; #(
  parameter int FAST_DIV = `HSTC_FAST_DIV
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_fast_sel,
  input  wire logic i_low_speed,
  output logic      o_tick
);

  localparam int DIVW = $clog2(FAST_DIV * `HSTC_LOW_SPEED_MUL) + 1;

  logic [DIVW-1:0] div_ff;
  logic [DIVW-1:0] limit;

  // ==============================================================
  // Fast path runs every FAST_DIV cycles, twice that in low speed
  always_comb begin
    if (!i_fast_sel) begin
      limit = DIVW'(1);
    end else if (i_low_speed) begin
      limit = DIVW'(FAST_DIV * `HSTC_LOW_SPEED_MUL);
    end else begin
      limit = DIVW'(FAST_DIV);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      div_ff <= '0;
      o_tick <= 1'b0;
    end else if (div_ff >= limit - DIVW'(1)) begin
      div_ff <= '0;
      o_tick <= 1'b1;
    end else begin
      div_ff <= div_ff + DIVW'(1);
      o_tick <= 1'b0;
    end
  end

endmodule

/* logic/hstc_timer.sv */
`timescale 1ns/1ps
`include "hstc_params.svh"

// What this block does
// RULE1: Override bits pair pins to outputs A, B, D
// RULE2: Low speed halves the fast peripheral clock
// RULE3: Low speed refused while PLL is system clock
// RULE4: Software stops timer before low speed change
// RULE5: Fast select clocks timer from PLL tick
// RULE6: Fast select needs PLL enabled first
// RULE7: PLL start runs PLL, reads one under fuse
// RULE8: Read-only lock bit after settling time
// RULE9: Control bits six to three read zero
// RULE10: Ten-bit counter, delayed CPU write
// RULE11: Counting resumes upward after counter write
// RULE12: Shared temp holds two high bits
// RULE13: Written equality never produces a match
// RULE14: Match sets flag after sync delay
// RULE15: Match with C clears the counter
// RULE16: C writes below three stored as three
// RULE17: Mask bits 7,6,5,2 gate interrupts globally; here each bit gates only its own request, and i_global_irq_en gates all
// RULE18: Requests carry vectors 10, 3, 9, 4
// RULE19: Flags clear on vector or delayed W1C
// RULE20: Flag bits 7 and 6 hold D, A
// RULE21: Overflow flag set when TOP wraps to zero
// RULE22: Flag bits 5 and 2 hold B, overflow
// RULE23: Temp pairs writes, low read captures high
// RULE24: Fast select write ignored without PLL
module hstc_timer import hstc_pkg::*; #(
  parameter int LOCK_CYCLES = `HSTC_PLL_LOCK_CYC,
  parameter int FAST_DIV    = `HSTC_FAST_DIV
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  input  wire hstc_io_req_t i_io,
  output logic [7:0]        o_io_rdata,
  input  wire logic [3:0]   i_clock_select_fuse,
  input  wire logic         i_global_irq_en,
  input  wire logic         i_irq_ack,
  input  wire logic [4:0]   i_irq_ack_vector,
  input  wire logic         i_count_en,
  input  wire logic [5:0]   i_override_en,
  input  wire logic [5:0]   i_port_out,
  input  wire logic [5:0]   i_port_dir,
  output logic              o_pll_run,
  output logic [2:0]        o_compare_out,
  output logic [5:0]        o_pin_out,
  output logic [5:0]        o_pin_oe,
  output logic [3:0]        o_irq_req,
  output logic [4:0]        o_irq_vector
);

  localparam int LCW = $clog2(LOCK_CYCLES + 1);

  function automatic hstc_cnt_t clamp_top(input hstc_cnt_t v);
    return (v < `HSTC_CMP_C_MIN) ? `HSTC_CMP_C_MIN : v;
  endfunction

  function automatic logic is_addr(input hstc_io_req_t r, input logic [5:0] a);
    return r.addr == a;
  endfunction

  function automatic logic [3:0] vec_hit(input logic [4:0] v);
    return {v == `HSTC_VEC_MATCH_D, v == `HSTC_VEC_MATCH_A,
            v == `HSTC_VEC_MATCH_B, v == `HSTC_VEC_OVERFLOW};
  endfunction

  // ==============================================================
  // State
  logic            low_speed_ff;
  logic            fast_sel_ff;
  logic            pll_start_ff;
  hstc_pll_state_t pll_state_ff;
  logic [LCW-1:0]  lock_cnt_ff;
  logic [1:0]      temp_ff;
  hstc_cnt_t       cnt_ff;
  hstc_cnt_t       cmp_a_ff;
  hstc_cnt_t       cmp_b_ff;
  hstc_cnt_t       cmp_c_ff;
  hstc_cnt_t       cmp_d_ff;
  hstc_evt_t       mask_ff;
  hstc_evt_t       flags_ff;
  hstc_evt_t       evt_ff;
  hstc_evt_t       clr_pend_ff;
  logic            wr1_v_ff;
  logic            wr2_v_ff;
  hstc_cnt_t       wr1_val_ff;
  hstc_cnt_t       wr2_val_ff;

  logic            pll_enabled;
  logic            pll_locked;
  logic            tick;
  logic            apply;
  hstc_cnt_t       load_val;
  hstc_cnt_t       cnt_step;
  logic            counting;
  hstc_evt_t       evt;
  hstc_evt_t       nxt_flags;
  hstc_cnt_t       wr10;
  logic [7:0]      rd_data;
  logic [1:0]      rd_hi;
  logic            rd_hi_v;

  assign wr10 = {temp_ff, i_io.wdata}; // RULE23
  // PLL counts as enabled by fuse or by software
  assign pll_enabled = pll_start_ff || (i_clock_select_fuse == `HSTC_FUSE_PLL); // RULE6
  assign pll_locked  = (pll_state_ff == PLL_LOCKED); // RULE8

  // ==============================================================
  // PLL control
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      low_speed_ff <= 1'b0;
      fast_sel_ff  <= 1'b0;
      pll_start_ff <= 1'b0;
    end else if (i_io.wr && is_addr(i_io, `HSTC_OFS_PLL_CTRL)) begin
      // Low speed cannot be entered while the PLL drives the system clock
      low_speed_ff <= i_io.wdata[`HSTC_BIT_LOW_SPEED] &&
                      (i_clock_select_fuse != `HSTC_FUSE_PLL); // RULE3 RULE2
      // A set attempt without an enabled PLL leaves the bit at zero
      fast_sel_ff  <= i_io.wdata[`HSTC_BIT_FAST_SEL] && pll_enabled; // RULE24 RULE6 RULE5
      pll_start_ff <= i_io.wdata[`HSTC_BIT_PLL_START]; // RULE7
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      pll_state_ff <= PLL_OFF;
      lock_cnt_ff  <= '0;
      o_pll_run    <= 1'b0;
    end else begin
      o_pll_run <= pll_enabled; // RULE7
      case (pll_state_ff)
        PLL_OFF: begin
          lock_cnt_ff <= '0;
          if (pll_enabled) begin
            pll_state_ff <= PLL_LOCKING;
          end
        end
        PLL_LOCKING: begin
          lock_cnt_ff <= lock_cnt_ff + LCW'(1);
          if (!pll_enabled) begin
            pll_state_ff <= PLL_OFF;
          end else if (lock_cnt_ff >= LCW'(LOCK_CYCLES - 1)) begin
            pll_state_ff <= PLL_LOCKED; // RULE8
          end
        end
        PLL_LOCKED: begin
          if (!pll_enabled) begin
            pll_state_ff <= PLL_OFF;
          end
        end
        default: begin
          pll_state_ff <= PLL_OFF;
        end
      endcase
    end
  end

  hstc_tick_gen #(
    .FAST_DIV (FAST_DIV)
  ) u_tick (
    .i_core_clk  (i_core_clk),
    .i_reset_n   (i_reset_n),
    .i_fast_sel  (fast_sel_ff),
    .i_low_speed (low_speed_ff),
    .o_tick      (tick)
  );

  // ==============================================================
  // Counter write pipeline: two stages in sync mode, one when fast
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      wr1_v_ff   <= 1'b0;
      wr2_v_ff   <= 1'b0;
      wr1_val_ff <= `HSTC_RST_CNT;
      wr2_val_ff <= `HSTC_RST_CNT;
    end else begin
      wr1_v_ff   <= i_io.wr && is_addr(i_io, `HSTC_OFS_CNT_LOW);
      wr1_val_ff <= wr10;
      wr2_v_ff   <= wr1_v_ff && !fast_sel_ff && (`HSTC_WR_SYNC_CYC > 1);
      wr2_val_ff <= wr1_val_ff;
    end
  end

  assign apply    = fast_sel_ff ? wr1_v_ff : (wr2_v_ff || (wr1_v_ff && `HSTC_WR_SYNC_CYC < 2)); // RULE10
  assign load_val = fast_sel_ff ? wr1_val_ff : wr2_val_ff;
  assign counting = tick && i_count_en && !apply;
  // Reaching C wraps to zero; values above C run on to the 10-bit wrap
  assign cnt_step = (cnt_ff == cmp_c_ff) ? `HSTC_RST_CNT : cnt_ff + 10'h001; // RULE15

  // A load never produces an event; only a counted step can match
  assign evt.match_d  = counting && (cnt_step == cmp_d_ff); // RULE13
  assign evt.match_a  = counting && (cnt_step == cmp_a_ff); // RULE13
  assign evt.match_b  = counting && (cnt_step == cmp_b_ff); // RULE13
  assign evt.overflow = counting && (cnt_ff == cmp_c_ff); // RULE21

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      cnt_ff <= `HSTC_RST_CNT;
    end else if (apply) begin
      cnt_ff <= load_val; // RULE11
    end else if (counting) begin
      cnt_ff <= cnt_step; // RULE10 RULE15
    end
  end

  // ==============================================================
  // Compare registers and shared temp
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      cmp_a_ff <= `HSTC_RST_CMP;
      cmp_b_ff <= `HSTC_RST_CMP;
      cmp_c_ff <= `HSTC_RST_CMP_C;
      cmp_d_ff <= `HSTC_RST_CMP;
    end else if (i_io.wr) begin
      if (is_addr(i_io, `HSTC_OFS_CMP_A)) cmp_a_ff <= wr10;
      if (is_addr(i_io, `HSTC_OFS_CMP_B)) cmp_b_ff <= wr10;
      if (is_addr(i_io, `HSTC_OFS_CMP_C)) cmp_c_ff <= clamp_top(wr10); // RULE16
      if (is_addr(i_io, `HSTC_OFS_CMP_D)) cmp_d_ff <= wr10;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      temp_ff <= 2'h0;
    end else if (i_io.wr && is_addr(i_io, `HSTC_OFS_HIGH_TEMP)) begin
      temp_ff <= i_io.wdata[1:0]; // RULE12
    end else if (i_io.rd && rd_hi_v) begin
      temp_ff <= rd_hi; // RULE23
    end
  end

  // ==============================================================
  // Interrupt mask, flags and requests
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      mask_ff <= '0;
    end else if (i_io.wr && is_addr(i_io, `HSTC_OFS_IRQ_MASK)) begin
      mask_ff <= {i_io.wdata[`HSTC_BIT_MATCH_D], i_io.wdata[`HSTC_BIT_MATCH_A],
                  i_io.wdata[`HSTC_BIT_MATCH_B], i_io.wdata[`HSTC_BIT_OVERFLOW]}; // RULE17
    end
  end

  // Set wins over both clears so an event in the clear cycle survives
  assign nxt_flags = (flags_ff & ~clr_pend_ff & ~(vec_hit(i_irq_ack_vector) & {4{i_irq_ack}}))
                     | evt_ff; // RULE19

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      evt_ff      <= '0;
      clr_pend_ff <= '0;
      flags_ff    <= '0;
    end else begin
      evt_ff      <= evt; // RULE14
      clr_pend_ff <= '0;
      if (i_io.wr && is_addr(i_io, `HSTC_OFS_IRQ_FLAGS)) begin
        clr_pend_ff <= {i_io.wdata[`HSTC_BIT_MATCH_D], i_io.wdata[`HSTC_BIT_MATCH_A],
                        i_io.wdata[`HSTC_BIT_MATCH_B], i_io.wdata[`HSTC_BIT_OVERFLOW]}; // RULE19
      end
      flags_ff <= nxt_flags; // RULE14 RULE20 RULE22
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_irq_req    <= 4'h0;
      o_irq_vector <= `HSTC_VEC_NONE;
    end else begin
      o_irq_req <= flags_ff & mask_ff & {4{i_global_irq_en}}; // RULE17
      // Lowest vector number is served first
      if (o_irq_req[2])      o_irq_vector <= `HSTC_VEC_MATCH_A; // RULE18
      else if (o_irq_req[0]) o_irq_vector <= `HSTC_VEC_OVERFLOW;
      else if (o_irq_req[1]) o_irq_vector <= `HSTC_VEC_MATCH_B;
      else if (o_irq_req[3]) o_irq_vector <= `HSTC_VEC_MATCH_D;
      else                   o_irq_vector <= `HSTC_VEC_NONE;
    end
  end

  // ==============================================================
  // Compare outputs and pin override
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_compare_out <= 3'h0;
      o_pin_out     <= 6'h00;
      o_pin_oe      <= 6'h00;
    end else begin
      o_compare_out <= o_compare_out ^ {evt.match_d, evt.match_b, evt.match_a};
      for (int i = 0; i < 6; i++) begin
        o_pin_out[i] <= i_override_en[i] ? o_compare_out[i/2] : i_port_out[i]; // RULE1
        o_pin_oe[i]  <= i_override_en[i] | i_port_dir[i]; // RULE1
      end
    end
  end

  // ==============================================================
  // Read path, one cycle latency
  always_comb begin
    rd_data = `HSTC_RST_BYTE;
    rd_hi   = 2'h0;
    rd_hi_v = 1'b1;
    case (i_io.addr)
      `HSTC_OFS_PLL_CTRL: begin
        rd_data[`HSTC_BIT_LOW_SPEED] = low_speed_ff; // RULE9
        rd_data[`HSTC_BIT_FAST_SEL]  = fast_sel_ff;
        rd_data[`HSTC_BIT_PLL_START] = pll_enabled; // RULE7
        rd_data[`HSTC_BIT_PLL_LOCK]  = pll_locked; // RULE8
        rd_hi_v = 1'b0;
      end
      `HSTC_OFS_IRQ_MASK: begin
        {rd_data[`HSTC_BIT_MATCH_D], rd_data[`HSTC_BIT_MATCH_A],
         rd_data[`HSTC_BIT_MATCH_B], rd_data[`HSTC_BIT_OVERFLOW]} = mask_ff;
        rd_hi_v = 1'b0;
      end
      `HSTC_OFS_IRQ_FLAGS: begin
        {rd_data[`HSTC_BIT_MATCH_D], rd_data[`HSTC_BIT_MATCH_A],
         rd_data[`HSTC_BIT_MATCH_B], rd_data[`HSTC_BIT_OVERFLOW]} = flags_ff; // RULE20 RULE22
        rd_hi_v = 1'b0;
      end
      `HSTC_OFS_HIGH_TEMP: begin
        rd_data = {6'h00, temp_ff}; // RULE12
        rd_hi_v = 1'b0;
      end
      `HSTC_OFS_CNT_LOW: {rd_hi, rd_data} = cnt_ff;
      `HSTC_OFS_CMP_A:   {rd_hi, rd_data} = cmp_a_ff;
      `HSTC_OFS_CMP_B:   {rd_hi, rd_data} = cmp_b_ff;
      `HSTC_OFS_CMP_C:   {rd_hi, rd_data} = cmp_c_ff;
      `HSTC_OFS_CMP_D:   {rd_hi, rd_data} = cmp_d_ff;
      default: begin
        rd_hi_v = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_io_rdata <= `HSTC_RST_BYTE;
    end else if (i_io.rd) begin
      o_io_rdata <= rd_data;
    end
  end

  // ==============================================================
  // Checks
  a_low_speed_refused: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // RULE3
    (i_io.wr && is_addr(i_io, `HSTC_OFS_PLL_CTRL) && i_clock_select_fuse == `HSTC_FUSE_PLL)
    |=> !low_speed_ff) else $error("low speed set under PLL system clock");

  a_fast_sel_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // RULE24
    $rose(fast_sel_ff) |-> $past(pll_enabled)) else $error("fast select set without PLL");

  a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // RULE9
    (i_io.rd && is_addr(i_io, `HSTC_OFS_PLL_CTRL)) |=> (o_io_rdata[6:3] == 4'h0))
    else $error("reserved control bits not zero");

  a_top_minimum: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // RULE16
    cmp_c_ff >= `HSTC_CMP_C_MIN) else $error("compare C below minimum");

  a_top_clears: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // RULE15
    (counting && cnt_ff == cmp_c_ff) |=> (cnt_ff == 10'h000 && evt_ff.overflow))
    else $error("counter not cleared at compare C");

  a_match_delay: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // RULE14
    evt.match_a |-> ##2 flags_ff.match_a) else $error("match A flag not set in time");

  a_load_no_match: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // RULE13
    apply |-> (evt == 4'h0)) else $error("counter load produced a match");

  a_flag_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // RULE19
    (i_io.wr && is_addr(i_io, `HSTC_OFS_IRQ_FLAGS) && i_io.wdata[`HSTC_BIT_MATCH_D])
    ##1 !evt_ff.match_d |=> !flags_ff.match_d) else $error("match D flag not cleared");

  a_cnt_write: assert property (@(posedge i_core_clk) disable iff (!i_reset_n) // RULE10
    (i_io.wr && is_addr(i_io, `HSTC_OFS_CNT_LOW) && !fast_sel_ff) ##1 !fast_sel_ff
    |=> ##1 (cnt_ff == $past(wr1_val_ff, 2))) else $error("counter write delay wrong");

endmodule

/* verif/hstc_timer_tb_top.sv */
`timescale 1ns/1ps
`include "hstc_params.svh"

module hstc_timer_tb_top import hstc_pkg::*; ;
  // ==============================================================
  // Stimulus and observed signals
  logic         i_core_clk;
  logic         i_reset_n;
  hstc_io_req_t io;
  logic [7:0]   rdata;
  logic [3:0]   fuse;
  logic         gie;
  logic         ack;
  logic [4:0]   ack_vec;
  logic         cnt_en;
  logic [5:0]   ovr_en;
  logic [5:0]   port_out;
  logic [5:0]   port_dir;
  logic         pll_run;
  logic [2:0]   cmp_out;
  logic [5:0]   pin_out;
  logic [5:0]   pin_oe;
  logic [3:0]   irq_req;
  logic [4:0]   irq_vec;
  logic [7:0]   exp_q[$];
  logic         rd_d;
  logic [31:0]  rnd;
  logic [7:0]   pin_exp;
  logic [7:0]   oe_exp;
  int           num_errors;
  int           total_checks;
  int           cycles;
  int           seed;

  hstc_timer #(
    .LOCK_CYCLES (8),
    .FAST_DIV    (1)
  ) i_dut (
    .i_core_clk          (i_core_clk),
    .i_reset_n           (i_reset_n),
    .i_io                (io),
    .o_io_rdata          (rdata),
    .i_clock_select_fuse (fuse),
    .i_global_irq_en     (gie),
    .i_irq_ack           (ack),
    .i_irq_ack_vector    (ack_vec),
    .i_count_en          (cnt_en),
    .i_override_en       (ovr_en),
    .i_port_out          (port_out),
    .i_port_dir          (port_dir),
    .o_pll_run           (pll_run),
    .o_compare_out       (cmp_out),
    .o_pin_out           (pin_out),
    .o_pin_oe            (pin_oe),
    .o_irq_req           (irq_req),
    .o_irq_vector        (irq_vec)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // ==============================================================
  // Compare and verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Read data is registered, so the note is taken one edge after the strobe
  always @(posedge i_core_clk) begin
    rd_d <= io.rd;
  end

  always @(negedge i_core_clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0) begin
        chk(rdata, 8'h00);
      end else begin
        chk(rdata, exp_q.pop_front());
      end
    end
  end

  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ==============================================================
  // Bus tasks; one idle edge between strobes keeps each drive single
  task automatic bus(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
    io <= {w, r, a, d};
    @(posedge i_core_clk);
    io <= '0;
    @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic wr10(input logic [5:0] a, input logic [9:0] v);
    wr(`HSTC_OFS_HIGH_TEMP, {6'h00, v[9:8]});
    wr(a, v[7:0]);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // ==============================================================
  // Main sequence
  initial begin
    io = '0;
    fuse = 4'h0;
    gie = 1'b0;
    ack = 1'b0;
    ack_vec = 5'h00;
    cnt_en = 1'b0;
    ovr_en = 6'h00;
    port_out = 6'h00;
    port_dir = 6'h00;
    seed = 12144;
    i_reset_n = 1'b0;
    idle(10);
    i_reset_n <= 1'b1;
    @(posedge i_core_clk);
    rd(`HSTC_OFS_PLL_CTRL, 8'h00);
    rd(`HSTC_OFS_IRQ_FLAGS, 8'h00);
    rd(6'h00, 8'h00);
    rd(`HSTC_OFS_CMP_C, 8'hff);
    rd(`HSTC_OFS_HIGH_TEMP, 8'h03);
    wr(`HSTC_OFS_IRQ_MASK, 8'hff);
    rd(`HSTC_OFS_IRQ_MASK, 8'he4);
    // Fast select refused since the PLL was off before this write
    wr(`HSTC_OFS_PLL_CTRL, 8'hff);
    rd(`HSTC_OFS_PLL_CTRL, 8'h82);
    @(negedge i_core_clk);
    chk({7'h00, pll_run}, 8'h01);
    @(posedge i_core_clk);
    idle(12);
    rd(`HSTC_OFS_PLL_CTRL, 8'h83);
    wr(`HSTC_OFS_PLL_CTRL, 8'h06);
    rd(`HSTC_OFS_PLL_CTRL, 8'h07);
    wr(`HSTC_OFS_PLL_CTRL, 8'h86);
    rd(`HSTC_OFS_PLL_CTRL, 8'h87);
    // Fast load takes one stage; low speed ticks every other cycle
    wr(`HSTC_OFS_CNT_LOW, 8'h10);
    cnt_en <= 1'b1;
    idle(8);
    cnt_en <= 1'b0;
    rd(`HSTC_OFS_CNT_LOW, 8'h14);
    wr(`HSTC_OFS_PLL_CTRL, 8'h00);
    idle(2);
    rd(`HSTC_OFS_PLL_CTRL, 8'h00);
    fuse <= `HSTC_FUSE_PLL;
    wr(`HSTC_OFS_PLL_CTRL, 8'h80);
    rd(`HSTC_OFS_PLL_CTRL, 8'h02);
    fuse <= 4'h0;
    wr(`HSTC_OFS_PLL_CTRL, 8'h00);
    // Shared temp register and 10-bit counter access
    wr(`HSTC_OFS_HIGH_TEMP, 8'hff);
    rd(`HSTC_OFS_HIGH_TEMP, 8'h03);
    wr10(`HSTC_OFS_CNT_LOW, 10'h255);
    wr(`HSTC_OFS_HIGH_TEMP, 8'h00);
    rd(`HSTC_OFS_CNT_LOW, 8'h55);
    rd(`HSTC_OFS_HIGH_TEMP, 8'h02);
    for (int v = 0; v < 3; v++) begin
      wr10(`HSTC_OFS_CMP_C, v[9:0]);
      rd(`HSTC_OFS_CMP_C, 8'h03);
    end
    rd(`HSTC_OFS_HIGH_TEMP, 8'h00);
    wr10(`HSTC_OFS_CMP_A, 10'h005);
    wr10(`HSTC_OFS_CNT_LOW, 10'h005);
    idle(4);
    rd(`HSTC_OFS_IRQ_FLAGS, 8'h00);
    // TOP of 0x10: A is hit twice across the wrap, B and D once
    wr10(`HSTC_OFS_CMP_C, 10'h010);
    wr10(`HSTC_OFS_CMP_A, 10'h001);
    wr10(`HSTC_OFS_CMP_B, 10'h006);
    wr10(`HSTC_OFS_CMP_D, 10'h007);
    wr10(`HSTC_OFS_CNT_LOW, 10'h000);
    wr(`HSTC_OFS_IRQ_MASK, 8'he4);
    gie <= 1'b1;
    cnt_en <= 1'b1;
    idle(20);
    cnt_en <= 1'b0;
    idle(4);
    rd(`HSTC_OFS_IRQ_FLAGS, 8'he4);
    @(negedge i_core_clk);
    chk({5'h00, cmp_out}, 8'h06);
    chk({4'h0, irq_req}, 8'h0f);
    chk({3'h0, irq_vec}, 8'h03);
    @(posedge i_core_clk);
    ack_vec <= `HSTC_VEC_MATCH_A;
    ack <= 1'b1;
    @(posedge i_core_clk);
    ack <= 1'b0;
    idle(3);
    rd(`HSTC_OFS_IRQ_FLAGS, 8'ha4);
    @(negedge i_core_clk);
    chk({3'h0, irq_vec}, 8'h04);
    @(posedge i_core_clk);
    wr(`HSTC_OFS_IRQ_FLAGS, 8'h04);
    idle(2);
    rd(`HSTC_OFS_IRQ_FLAGS, 8'ha0);
    @(negedge i_core_clk);
    chk({3'h0, irq_vec}, 8'h09);
    @(posedge i_core_clk);
    wr(`HSTC_OFS_IRQ_MASK, 8'h80);
    idle(3);
    @(negedge i_core_clk);
    chk({4'h0, irq_req}, 8'h08);
    chk({3'h0, irq_vec}, 8'h10);
    @(posedge i_core_clk);
    gie <= 1'b0;
    idle(3);
    @(negedge i_core_clk);
    chk({4'h0, irq_req}, 8'h00);
    @(posedge i_core_clk);
    wr(`HSTC_OFS_IRQ_FLAGS, 8'h80);
    idle(2);
    rd(`HSTC_OFS_IRQ_FLAGS, 8'h20);
    // Compare outputs now stand at D=1, B=1, A=0
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      ovr_en <= rnd[5:0];
      port_out <= rnd[11:6];
      port_dir <= rnd[17:12];
      idle(3);
      pin_exp = 8'h00;
      oe_exp = 8'h00;
      for (int j = 0; j < 6; j++) begin
        pin_exp[j] = rnd[j] ? (j >= 2) : rnd[6 + j];
        oe_exp[j] = rnd[j] ? 1'b1 : rnd[12 + j];
      end
      @(negedge i_core_clk);
      chk({2'h0, pin_out}, pin_exp);
      chk({2'h0, pin_oe}, oe_exp);
      @(posedge i_core_clk);
    end
    idle(2);
    tally_and_finish();
  end
endmodule
